// >>> rtl/ldr_cell.sv
// logic cell with two look-up tables usable as distributed ram
// Function
// - two independent 16x1 memories, shared/separate address
// - 32x1: second data input is address bit
// - one table ram, others do logic
// - sync mode writes only on chosen edge
// - async mode: enable level is strobe
// - one timing mode for both tables
// - dual port: one write, two reads
// - reads combinational in every mode
// - four table inputs form address
// - control inputs become data and enable
// - table output leaves directly or registered; here every output is registered
// - third table and flip-flop source select
// - edge samples address, data, enable, then writes
// - write edge rising default or falling; here the fall bit picks which alternate rising edge writes
// - one write polarity for both tables
// - write enable active high, not invertible
// - dual port: primary address reads first, writes
// - dual port: second address reads second table
// - dual port always edge timed
// - async mode writes while enable high
// - contents loaded at configuration, reset untouched
//
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/10ps
`include "ldr_regs.svh"
module ldr_cell (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [3:0]  first_table_inputs_i,
	input  wire logic [3:0]  second_table_inputs_i,
	input  wire logic        write_data_first_i,
	input  wire logic        write_data_second_i,
	input  wire logic        write_enable_i,
	input  wire logic        third_table_input_one_i,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output      logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output      logic        s_axi_wready,
	output      logic [1:0]  s_axi_bresp,
	output      logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output      logic        s_axi_arready,
	output      logic [31:0] s_axi_rdata,
	output      logic [1:0]  s_axi_rresp,
	output      logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output      logic        single_port_output_o,
	output      logic        dual_port_output_o,
	output      logic        third_table_output_o,
	output      logic        cell_ff_o
);
	import ldr_pkg::*;

	logic [31:0] config_reg;
	logic [31:0] flogic;
	logic [15:0] init_f;
	logic [15:0] init_g;
	logic        load_f;
	logic        load_g;
	ldr_mode_e   mode;
	ldr_ffsel_e  ffsel;
	logic        async_mode;
	logic        fall_edge;
	logic [3:0]  a_s1;
	logic [3:0]  a_s2;
	logic [3:0]  b_s1;
	logic [3:0]  b_s2;
	logic [3:0]  c_s1;
	logic [3:0]  c_s2;
	logic        edge_seen;
	logic        f_out;
	logic        g_out;
	logic        f_wr;
	logic        g_wr;
	logic        f_din;
	logic        g_din;
	logic [3:0]  f_waddr;
	logic [3:0]  g_waddr;
	logic [3:0]  g_raddr;
	logic        next_spo;
	logic        next_dpo;
	logic        next_h;
	logic        next_ff;
	logic        aw_held;
	logic        w_held;
	logic [31:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        wr_go;
	logic        wr_hit;
	logic [31:0] rd_val;
	logic        rd_hit;

	assign mode       = ldr_mode_e'(config_reg[`LDR_CFG_MODE_LSB +: 3]);
	assign ffsel      = ldr_ffsel_e'(config_reg[`LDR_CFG_FFSEL_LSB +: 2]);
	// dual port forces edge timing regardless of the async bit
	assign async_mode = config_reg[`LDR_CFG_ASYNC_BIT] && (mode != LDR_DP16X1);
	assign fall_edge  = config_reg[`LDR_CFG_FALL_BIT];

	// pins come from fabric outside our clock: two flops each
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			a_s1 <= 4'h0;
			a_s2 <= 4'h0;
			b_s1 <= 4'h0;
			b_s2 <= 4'h0;
			c_s1 <= 4'h0;
			c_s2 <= 4'h0;
		end else begin
			a_s1 <= first_table_inputs_i;
			a_s2 <= a_s1;
			b_s1 <= second_table_inputs_i;
			b_s2 <= b_s1;
			c_s1 <= {third_table_input_one_i, write_enable_i, write_data_second_i,
				write_data_first_i};
			c_s2 <= c_s1;
		end
	end

	// one clock only: the write clock phase is a toggle of the system clock,
	// so a sync write lands on every other edge, the fall bit picking which
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			edge_seen <= 1'b0;
		end else begin
			edge_seen <= ~edge_seen;
		end
	end

	// write strobe: sync samples enable on the selected phase, async follows level
	logic sync_edge;
	assign sync_edge = fall_edge ? edge_seen : ~edge_seen;
	logic wr_strobe;
	assign wr_strobe = async_mode ? c_s2[2] : (c_s2[2] & sync_edge);

	always_comb begin
		f_wr    = 1'b0;
		g_wr    = 1'b0;
		f_din   = c_s2[0];
		g_din   = c_s2[1];
		f_waddr = a_s2;
		g_waddr = b_s2;
		g_raddr = b_s2;
		case (mode)
			LDR_SP16X1: begin
				f_wr = wr_strobe;
			end
			LDR_SP16X2: begin
				f_wr = wr_strobe;
				g_wr = wr_strobe;
			end
			LDR_SP32X1: begin
				// second data input picks the table, first is the data
				f_wr    = wr_strobe & ~c_s2[1];
				g_wr    = wr_strobe & c_s2[1];
				g_din   = c_s2[0];
				g_waddr = a_s2;
				g_raddr = a_s2;
			end
			LDR_DP16X1: begin
				f_wr    = wr_strobe;
				g_wr    = wr_strobe;
				g_din   = c_s2[0];
				g_waddr = a_s2;
				g_raddr = b_s2;
			end
			default: begin
				f_wr = 1'b0;
			end
		endcase
	end

	// tables hold their contents across rst_i; only a config load or a ram write changes them
	ldr_lut16 u_f (
		.clk_i      (clk_i),
		.load_i     (load_f),
		.load_val_i (init_f),
		.wr_i       (f_wr),
		.wr_addr_i  (f_waddr),
		.wr_data_i  (f_din),
		.rd_addr_i  (a_s2),
		.rd_data_o  (f_out)
	);

	ldr_lut16 u_g (
		.clk_i      (clk_i),
		.load_i     (load_g),
		.load_val_i (init_g),
		.wr_i       (g_wr),
		.wr_addr_i  (g_waddr),
		.wr_data_i  (g_din),
		.rd_addr_i  (g_raddr),
		.rd_data_o  (g_out)
	);

	// in logic mode tables are lookup functions of their pins
	always_comb begin
		next_spo = f_out;
		next_dpo = g_out;
		if (mode == LDR_SP32X1) begin
			next_spo = c_s2[1] ? g_out : f_out;
		end else if (mode == LDR_LOGIC) begin
			next_spo = flogic[a_s2];
		end
		// third table: programmable function of f, g and second data input
		next_h = flogic[{1'b1, f_out, g_out, c_s2[1]}];
		case (ffsel)
			LDR_FF_F:  next_ff = f_out;
			LDR_FF_G:  next_ff = g_out;
			LDR_FF_H:  next_ff = next_h;
			default:   next_ff = c_s2[0];
		endcase
	end

	// outputs registered, so reads reach the pins one cycle after the address
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			single_port_output_o <= 1'b0;
			dual_port_output_o   <= 1'b0;
			third_table_output_o <= 1'b0;
			cell_ff_o            <= 1'b0;
		end else begin
			single_port_output_o <= next_spo;
			dual_port_output_o   <= next_dpo;
			third_table_output_o <= next_h;
			cell_ff_o            <= next_ff;
		end
	end

	// axi4-lite write side
	assign wr_go = aw_held && w_held && !s_axi_bvalid;
	always_comb begin
		wr_hit = 1'b1;
		if (aw_addr[7:0] == `LDR_OFF_CONFIG) begin
			wr_hit = 1'b1;
		end else if (aw_addr[7:0] == `LDR_OFF_FLOGIC) begin
			wr_hit = 1'b1;
		end else if (aw_addr[7:0] == `LDR_OFF_INIT_F) begin
			wr_hit = 1'b1;
		end else if (aw_addr[7:0] == `LDR_OFF_INIT_G) begin
			wr_hit = 1'b1;
		end else begin
			wr_hit = 1'b0;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= 32'h0000_0000;
			w_data        <= 32'h0000_0000;
			w_strb        <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `LDR_OKAY;
		end else begin
			s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
			s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? `LDR_OKAY : `LDR_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// register contents; byte lanes honoured
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			config_reg <= `LDR_CFG_RESET;
			flogic     <= `LDR_FLOGIC_RESET;
			init_f     <= `LDR_INIT_RESET;
			init_g     <= `LDR_INIT_RESET;
			load_f     <= 1'b0;
			load_g     <= 1'b0;
		end else begin
			load_f <= 1'b0;
			load_g <= 1'b0;
			if (wr_go) begin
				for (int i = 0; i < 4; i++) begin
					if (w_strb[i]) begin
						if (aw_addr[7:0] == `LDR_OFF_CONFIG) begin
							config_reg[i*8 +: 8] <= w_data[i*8 +: 8];
						end else if (aw_addr[7:0] == `LDR_OFF_FLOGIC) begin
							flogic[i*8 +: 8] <= w_data[i*8 +: 8];
						end else if (aw_addr[7:0] == `LDR_OFF_INIT_F && i < 2) begin
							init_f[i*8 +: 8] <= w_data[i*8 +: 8];
						end else if (aw_addr[7:0] == `LDR_OFF_INIT_G && i < 2) begin
							init_g[i*8 +: 8] <= w_data[i*8 +: 8];
						end
					end
				end
				// configuration load: a write to an init word loads that table
				load_f <= (aw_addr[7:0] == `LDR_OFF_INIT_F);
				load_g <= (aw_addr[7:0] == `LDR_OFF_INIT_G);
			end
		end
	end

	// axi4-lite read side
	always_comb begin
		rd_val = 32'h0000_0000;
		rd_hit = 1'b1;
		if (s_axi_araddr[7:0] == `LDR_OFF_CONFIG) begin
			rd_val = config_reg;
		end else if (s_axi_araddr[7:0] == `LDR_OFF_ADDR) begin
			rd_val = {24'h00_0000, b_s2, a_s2};
		end else if (s_axi_araddr[7:0] == `LDR_OFF_DATA) begin
			rd_val = {28'h000_0000, c_s2};
		end else if (s_axi_araddr[7:0] == `LDR_OFF_STATUS) begin
			rd_val = {27'h000_0000, async_mode, next_ff, next_h, g_out, f_out};
		end else if (s_axi_araddr[7:0] == `LDR_OFF_FLOGIC) begin
			rd_val = flogic;
		end else if (s_axi_araddr[7:0] == `LDR_OFF_INIT_F) begin
			rd_val = {16'h0000, init_f};
		end else if (s_axi_araddr[7:0] == `LDR_OFF_INIT_G) begin
			rd_val = {16'h0000, init_g};
		end else begin
			rd_hit = 1'b0;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `LDR_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_val;
				s_axi_rresp  <= rd_hit ? `LDR_OKAY : `LDR_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule

// >>> inc/ldr_regs.svh
// offsets, fields, reset values and timing counts for the lut ram cell
`ifndef LDR_REGS_SVH
`define LDR_REGS_SVH
`define LDR_CLK_PERIOD_NS   10
`define LDR_OFF_CONFIG      32'h0000_0000
`define LDR_OFF_ADDR        32'h0000_0004
`define LDR_OFF_DATA        32'h0000_0008
`define LDR_OFF_STATUS      32'h0000_000c
`define LDR_OFF_FLOGIC      32'h0000_0010
`define LDR_OFF_INIT_F      32'h0000_0014
`define LDR_OFF_INIT_G      32'h0000_0018
`define LDR_CFG_MODE_LSB    0
`define LDR_CFG_ASYNC_BIT   3
`define LDR_CFG_FALL_BIT    4
`define LDR_CFG_FFSEL_LSB   5
`define LDR_CFG_RESET       32'h0000_0000
`define LDR_FLOGIC_RESET    32'h0000_0000
`define LDR_INIT_RESET      16'h0000
`define LDR_SLVERR          2'b10
`define LDR_OKAY            2'b00
`endif

// >>> inc/ldr_pkg.sv
// types for the lut ram cell
package ldr_pkg;
	typedef enum logic [2:0] {
		LDR_LOGIC,
		LDR_SP16X1,
		LDR_SP16X2,
		LDR_SP32X1,
		LDR_DP16X1
	} ldr_mode_e;
	typedef enum logic [1:0] {
		LDR_FF_F,
		LDR_FF_G,
		LDR_FF_H,
		LDR_FF_D0
	} ldr_ffsel_e;
	typedef logic [15:0] ldr_table_t;
endpackage

// >>> rtl/ldr_lut16.sv
// one 16-entry look-up table usable as ram
`timescale 1ns/10ps
module ldr_lut16 (
	input  wire logic        clk_i,
	input  wire logic        load_i,
	input  wire logic [15:0] load_val_i,
	input  wire logic        wr_i,
	input  wire logic [3:0]  wr_addr_i,
	input  wire logic        wr_data_i,
	input  wire logic [3:0]  rd_addr_i,
	output      logic        rd_data_o
);
	logic [15:0] cells;

	// contents have no reset: only a load changes them outside writes
	always_ff @(posedge clk_i) begin
		if (load_i) begin
			cells <= load_val_i;
		end else if (wr_i) begin
			cells[wr_addr_i] <= wr_data_i;
		end
	end

	assign rd_data_o = cells[rd_addr_i];
endmodule

// >>> tb/ldr_cell_sva.sv
// protocol and read-path checks for the lut ram cell
`timescale 1ns/10ps
`include "ldr_regs.svh"
module ldr_cell_sva (
	input logic		clk_i,
	input logic		rst_i,
	input logic [3:0]	first_table_inputs_i,
	input logic [3:0]	second_table_inputs_i,
	input logic		write_data_second_i,
	input logic		write_enable_i,
	input logic		s_axi_awvalid,
	input logic		s_axi_awready,
	input logic		s_axi_bvalid,
	input logic		s_axi_bready,
	input logic		s_axi_arready,
	input logic [31:0]	s_axi_rdata,
	input logic [1:0]	s_axi_rresp,
	input logic		s_axi_rvalid,
	input logic		s_axi_rready,
	input logic		single_port_output_o,
	input logic		dual_port_output_o
);
	logic [3:0]	quiet;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// sync stages and output register settle well inside six cycles
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			quiet <= 4'h0;
		else if (write_enable_i || s_axi_awvalid || !$stable({first_table_inputs_i,
			second_table_inputs_i, write_data_second_i}))
			quiet <= 4'h0;
		else if (quiet != 4'hf)
			quiet <= quiet + 4'h1;
	end
	a_read_steady: assert property (quiet > 4'h5 |->
		$stable(single_port_output_o) && $stable(dual_port_output_o)) else $error("read moved");
	a_b_single: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer repeated");
	a_r_single: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer repeated");
	a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("awready too long");
	a_aw_cause: assert property (s_axi_awready |-> $past(s_axi_awvalid))
		else $error("awready unasked");
	a_read_answer: assert property (s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == `LDR_SLVERR |->
		s_axi_rdata == 32'h0) else $error("error read carries data");
	a_reset_quiet: assert property ($fell(rst_i) |-> !s_axi_bvalid && !s_axi_rvalid
		&& !single_port_output_o && !dual_port_output_o) else $error("outputs live at reset");
endmodule
bind ldr_cell ldr_cell_sva i_ldr_cell_sva (.*);

// >>> tb/ldr_fabric.sv
// fabric logic beside the cell: launches address, data and enable pins
`timescale 1ns/10ps
module ldr_fabric (
	input logic		clk_i,
	input logic [11:0]	cmd_i,
	output logic [11:0]	pins_o
);
	initial pins_o = 12'h0;
	// launched just after each edge and held; the clock is never parked
	always @(posedge clk_i)
		pins_o <= cmd_i;
endmodule

// >>> tb/testbench.sv
// self-checking bench: fabric pins and register port of the lut ram cell
`timescale 1ns/10ps
`include "ldr_regs.svh"
module testbench;
	import ldr_pkg::*;
	logic		clk_i = 1'b0, rst_i = 1'b1, smp = 1'b0;
	logic		awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
	logic [11:0]	cmd = 12'h0;
	logic [31:0]	awa = 32'h0, wd = 32'h0, ara = 32'h0;
	logic [31:0]	rd;
	logic [11:0]	pin;
	logic		awr, wr, bv, arr, rv, single_port_output, dual_port_output, ff, th;
	logic [31:0]	fl = 32'h0;
	logic [1:0]	bresp, rresp;
	logic [33:0]	got;
	logic [33:0]	q_exp[$];
	logic [33:0]	q_msk[$];
	logic [15:0]	mf, mg;
	ldr_mode_e	md;
	ldr_ffsel_e	fs = LDR_FF_F;
	logic [7:0]	cfgs[9] = '{8'h02, 8'h12, 8'h0a, 8'h09, 8'h0c,
		8'h20, 8'h41, 8'h62, 8'h13};
	int		num_errors = 0;
	int		total_checks = 0;
	ldr_fabric i_ldr_fabric (.clk_i(clk_i), .cmd_i(cmd), .pins_o(pin));
	ldr_cell i_ldr_cell (.clk_i(clk_i), .rst_i(rst_i), .first_table_inputs_i(pin[3:0]),
		.second_table_inputs_i(pin[7:4]), .write_data_first_i(pin[8]),
		.write_data_second_i(pin[9]), .write_enable_i(pin[10]),
		.third_table_input_one_i(pin[11]), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
		.s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
		.s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
		.single_port_output_o(single_port_output), .dual_port_output_o(dual_port_output),
		.third_table_output_o(th), .cell_ff_o(ff));
	always #5 clk_i = ~clk_i;
	task automatic chk(input logic [33:0] e, m);
		q_exp.push_back(e);
		q_msk.push_back(m);
	endtask
	task automatic axw(input logic [31:0] a, d, input logic [1:0] r);
		logic ta = 1'b0, tw = 1'b0;
		chk({r, 32'h0}, {2'h3, 32'h0});
		@(posedge clk_i);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		do begin
			@(posedge clk_i);
			ta |= awr;
			tw |= wr;
			if (ta) awv <= 1'b0;
			if (tw) wv <= 1'b0;
		end while (!(ta && tw));
		while (!bv) @(posedge clk_i);
		br <= 1'b0;
	endtask
	task automatic axr(input logic [31:0] a, input logic [33:0] e);
		chk(e, {34{1'b1}});
		@(posedge clk_i);
		ara <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		do @(posedge clk_i); while (!arr);
		arv <= 1'b0;
		while (!rv) @(posedge clk_i);
		rr <= 1'b0;
	endtask
	task automatic rst8();
		rst_i <= 1'b1;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
	endtask
	// pins are held eight cycles, nine when checked, past the input sync and output register
	task automatic dr(input logic [3:0] a, b, input logic d0, d1, w, lk);
		logic s, f, g, h, x;
		f = mf[a];
		g = (md == LDR_SP32X1) ? mg[a] : mg[b];
		s = (md == LDR_SP32X1 && d1) ? mg[a] : f;
		if (md == LDR_LOGIC)
			s = fl[a];
		h = fl[{1'b1, f, g, d1}];
		x = (fs == LDR_FF_F) ? f : (fs == LDR_FF_G) ? g : (fs == LDR_FF_H) ? h : d0;
		cmd <= {1'($urandom), w, d1, d0, b, a};
		repeat (8) @(posedge clk_i);
		if (lk) begin
			chk({30'h0, h, x, s, g}, {34{1'b1}});
			smp <= 1'b1;
			@(posedge clk_i);
			smp <= 1'b0;
		end
	endtask
	task automatic sweep();
		for (int i = 0; i < 32; i++)
			dr(4'(i), 4'(~i), 1'b0, 1'(i >> 4), 1'b0, 1'b1);
	endtask
	task automatic setup(input logic [7:0] c);
		md = ldr_mode_e'(c[2:0]);
		fs = ldr_ffsel_e'(c[6:5]);
		mf = 16'($urandom);
		mg = (md == LDR_SP32X1) ? mf : 16'($urandom);
		fl = $urandom;
		axw(`LDR_OFF_CONFIG, {24'h0, c}, `LDR_OKAY);
		axr(`LDR_OFF_CONFIG, {`LDR_OKAY, 24'h0, c});
		axw(`LDR_OFF_FLOGIC, fl, `LDR_OKAY);
		axr(`LDR_OFF_FLOGIC, {`LDR_OKAY, fl});
		axw(`LDR_OFF_INIT_F, {16'h0, mf}, `LDR_OKAY);
		axw(`LDR_OFF_INIT_G, {16'h0, mg}, `LDR_OKAY);
	endtask
	task automatic op(input logic [3:0] a, b, input logic d0, d1, w);
		dr(a, b, d0, d1, 1'b0, 1'b1);
		dr(a, b, d0, d1, w, 1'b0);
		dr(a, b, !d0, d1, w, 1'b0);
		if (w && md == LDR_SP32X1 && d1)
			mg[a] = !d0;
		else if (w && md != LDR_LOGIC)
			mf[a] = !d0;
		if (w && md == LDR_DP16X1)
			mg[a] = !d0;
		else if (w && md == LDR_SP16X2)
			mg[b] = d1;
		dr(a, b, d0, d1, 1'b0, 1'b1);
	endtask
	always @(posedge clk_i) begin
		if (smp || (bv && br) || (rv && rr)) begin
			got = smp ? {30'h0, th, ff, single_port_output, dual_port_output} : (rv ? {rresp, rd} : {bresp, 32'h0});
			total_checks++;
			if ((got & q_msk[0]) !== q_exp[0]) begin
				num_errors++;
				$display("unexpected at %0t: got %h, expected %h", $time, got & q_msk[0], q_exp[0]);
			end
			q_exp.delete(0);
			q_msk.delete(0);
		end
	end
	task automatic summarize();
		$display("checks %0d, mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// roughly six times the expected run of some six thousand cycles
	initial begin
		#400000;
		num_errors++;
		summarize();
	end
	initial begin
		void'($urandom(76994));
		rst8();
		axr(`LDR_OFF_CONFIG, {`LDR_OKAY, `LDR_CFG_RESET});
		axr(32'h40, {`LDR_SLVERR, 32'h0});
		axw(32'h40, 32'h1, `LDR_SLVERR);
		$display("register port test done");
		foreach (cfgs[k]) begin
			setup(cfgs[k]);
			sweep();
			repeat (10) op(4'($urandom), 4'($urandom), 1'($urandom), 1'($urandom), 1'($urandom));
			$display("mode %h test done", cfgs[k]);
		end
		rst8();
		fl = `LDR_FLOGIC_RESET;
		axw(`LDR_OFF_CONFIG, {24'h0, cfgs[8]}, `LDR_OKAY);
		sweep();
		$display("reset retention test done");
		summarize();
	end
endmodule
